// [rtl/bths_params.svh]
`ifndef BTHS_PARAMS_SVH
`define BTHS_PARAMS_SVH

// ****************************************************************
// Clock figures
// ****************************************************************
`define BTHS_MCLK_HZ 10000000
`define BTHS_SCLK_MAX_HZ 16000000

// ****************************************************************
// Sizes
// ****************************************************************
`define BTHS_BUF_DEPTH 2048
`define BTHS_BYTE_W 8
`define BTHS_BIT_CNT_W 3
`define BTHS_SYNC_W 5

// ****************************************************************
// Positions in the synchroniser vector
// ****************************************************************
`define BTHS_SY_PWR 0
`define BTHS_SY_TXACK 1
`define BTHS_SY_RXTGL 2
`define BTHS_SY_CS 3
`define BTHS_SY_STRAP 4

// ****************************************************************
// Reset values
// ****************************************************************
`define BTHS_RST_BYTE 8'h00
`define BTHS_RST_CNT 3'h0
`define BTHS_RST_OE_N 1'b1

`endif

// [rtl/bths_pkg.sv]
`default_nettype none

// ****************************************************************
// Types shared by the transport
// ****************************************************************
package bths_pkg;
	// Transaction start negotiation states
	typedef enum logic [1:0] {
		BTHS_ST_IDLE,
		BTHS_ST_REQ,
		BTHS_ST_XFER
	} bths_state_t;
endpackage

`default_nettype wire

// [rtl/bths_sync.sv]
`include "bths_params.svh"
`default_nettype none

// ****************************************************************
// Two flip-flop level synchroniser, one lane per bit
// ****************************************************************
module bths_sync #(
	parameter int W = `BTHS_SYNC_W
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_q; // First stage, read only by the second

	// Both stages clear to zero under synchronous reset
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			meta_q <= '0;
			o_q <= '0;
		end else begin
			meta_q <= i_d;
			o_q <= meta_q;
		end
	end
endmodule

`default_nettype wire

// [rtl/bths_spi_transport.sv]
`include "bths_params.svh"
`default_nettype none

module bths_spi_transport
	import bths_pkg::*;
#(
	parameter int DEPTH = `BTHS_BUF_DEPTH
) (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_link_sclk,
	input wire logic i_slave_select_in,
	input wire logic i_mosi,
	output logic o_miso,
	output logic o_miso_oe_n,
	output logic o_int,
	output logic o_int_oe_n,
	input wire logic i_radio_core_power_enable,
	input wire logic i_host_wake_transport_strap,
	input wire logic i_cs_active_high,
	input wire logic i_int_active_high,
	input wire logic i_lsb_first,
	input wire logic i_xfer_ready,
	output logic o_spi_selected,
	output logic o_core_reset_n,
	output logic o_rx_valid,
	output logic [7:0] o_rx_data,
	input wire logic i_rx_ready,
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_data,
	output logic o_tx_ready,
	output logic o_rx_overflow
);
	// ****************************************************************
	// Parameters and checks
	// ****************************************************************
	localparam int AW = $clog2(DEPTH);
	localparam int MCLK_HZ = `BTHS_MCLK_HZ;
	localparam int SCLK_MAX_HZ = `BTHS_SCLK_MAX_HZ;
	// Link bit periods per byte, in core cycles, rounded down
	localparam int BYTE_CYC = (8 * MCLK_HZ) / SCLK_MAX_HZ;

	// The byte crossing needs about four core cycles per byte
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("DEPTH must be a power of two of at least 2");
	end
	if (BYTE_CYC < 4) begin : g_bad_rate
		$error("Core clock too slow for the link rate");
	end

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [`BTHS_SYNC_W-1:0] sy_d; // Raw asynchronous levels
	logic [`BTHS_SYNC_W-1:0] sy_q; // Synchronised levels
	logic pwr_s; // Power enable, synchronised
	logic cs_act_s; // Select active, synchronised
	logic strap_s; // Strap level, synchronised
	logic rst_n_q; // Core reset, active low
	logic strap_done_q; // Strap captured since power-up
	logic spi_sel_q; // Serial slave transport chosen
	logic cs_act_raw; // Select active, link side
	logic link_rst_n; // Frame reset for the link counters
	logic [2:0] rx_cnt_q; // Receive bit count
	logic [7:0] rx_sh_q; // Receive shifter
	logic [7:0] rx_next; // Byte including the current bit
	logic [7:0] rx_byte_q; // Last complete received byte
	logic rx_tgl_q; // Flips once per received byte
	logic [2:0] tx_cnt_q; // Transmit bit count
	logic [7:0] tx_cur_q; // Byte being sent
	logic tx_ack_q; // Flips when a byte is taken
	logic rx_tgl_d_q; // Previous receive toggle
	logic tx_ack_d_q; // Previous acknowledge toggle
	logic rx_edge; // A new byte arrived
	logic ack_edge; // Next byte was taken
	logic [7:0] rx_mem [DEPTH]; // Receive packet buffer
	logic [AW:0] rx_wp_q; // Receive write pointer
	logic [AW:0] rx_rp_q; // Receive read pointer
	logic rx_full; // Receive buffer full
	logic rx_empty; // Receive buffer empty
	logic rx_push; // Store a received byte
	logic rx_pop; // Move a byte to the output stage
	logic [7:0] tx_mem [DEPTH]; // Transmit packet buffer
	logic [AW:0] tx_wp_q; // Transmit write pointer
	logic [AW:0] tx_rp_q; // Transmit read pointer
	logic [AW:0] tx_wp_d; // Next transmit write pointer
	logic [AW:0] tx_rp_d; // Next transmit read pointer
	logic tx_push; // Accept a byte from the user
	logic tx_load; // Move a byte to the next-byte stage
	logic [7:0] tx_nx_q; // Byte offered to the link
	logic tx_nx_full_q; // Offered byte is valid
	logic pend; // Data waiting for the master
	bths_state_t st_q; // Negotiation state
	bths_state_t st_d; // Next negotiation state

	// Picks one bit of a byte in the chosen order
	function automatic logic pick(input logic [7:0] b, input logic [2:0] n,
		input logic lsb);
		return lsb ? b[n] : b[3'h7 - n];
	endfunction

	// ****************************************************************
	// Crossing into the core clock
	// ****************************************************************
	assign sy_d[`BTHS_SY_PWR] = i_radio_core_power_enable;
	assign sy_d[`BTHS_SY_TXACK] = tx_ack_q;
	assign sy_d[`BTHS_SY_RXTGL] = rx_tgl_q;
	assign sy_d[`BTHS_SY_CS] = i_slave_select_in;
	assign sy_d[`BTHS_SY_STRAP] = i_host_wake_transport_strap;

	// Power, select and strap pins and both link toggles pass two flip-flops
	bths_sync #(
		.W(`BTHS_SYNC_W)
	) u_sync (
		.i_clk(i_mclk),
		.i_rst_n(i_nrst),
		.i_d(sy_d),
		.o_q(sy_q)
	);

	assign pwr_s = sy_q[`BTHS_SY_PWR];
	assign strap_s = sy_q[`BTHS_SY_STRAP];
	assign cs_act_s = sy_q[`BTHS_SY_CS] ~^ i_cs_active_high;
	assign rx_edge = sy_q[`BTHS_SY_RXTGL] ^ rx_tgl_d_q;
	assign ack_edge = sy_q[`BTHS_SY_TXACK] ^ tx_ack_d_q;

	// ****************************************************************
	// Power and reset
	// ****************************************************************

	// Core held in reset while the power enable is low
	always_ff @(posedge i_mclk) begin
		rst_n_q <= i_nrst && pwr_s;
	end
	assign o_core_reset_n = rst_n_q;

	// Strap read once after each power-up; low selects this transport
	always_ff @(posedge i_mclk) begin
		if (!rst_n_q) begin
			strap_done_q <= 1'b0;
			spi_sel_q <= 1'b0;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			spi_sel_q <= !strap_s;
		end
	end
	assign o_spi_selected = spi_sel_q;

	// ****************************************************************
	// Link clock domain
	// ****************************************************************
	// Mode: master drives on rising, device drives on rising and
	// samples on falling. Counters clear whenever select drops, so a
	// stopped clock never leaves a half byte behind.
	assign cs_act_raw = i_slave_select_in ~^ i_cs_active_high;
	assign link_rst_n = cs_act_raw && rst_n_q;
	assign rx_next = i_lsb_first ? {i_mosi, rx_sh_q[7:1]}
		: {rx_sh_q[6:0], i_mosi};

	// Receive shifter and bit count on falling edges
	always_ff @(negedge i_link_sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			rx_cnt_q <= `BTHS_RST_CNT;
			rx_sh_q <= `BTHS_RST_BYTE;
		end else begin
			rx_cnt_q <= rx_cnt_q + 3'h1;
			rx_sh_q <= rx_next;
		end
	end

	// Completed byte and its toggle survive the end of the frame
	always_ff @(negedge i_link_sclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rx_byte_q <= `BTHS_RST_BYTE;
			rx_tgl_q <= 1'b0;
		end else if (cs_act_raw && rx_cnt_q == 3'h7) begin
			rx_byte_q <= rx_next;
			rx_tgl_q <= !rx_tgl_q;
		end
	end

	// Transmit bit count and data out on rising edges
	always_ff @(posedge i_link_sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tx_cnt_q <= `BTHS_RST_CNT;
			tx_cur_q <= `BTHS_RST_BYTE;
			o_miso <= 1'b0;
		end else begin
			tx_cnt_q <= tx_cnt_q + 3'h1;
			if (tx_cnt_q == 3'h0) begin
				// Next byte is held still by the core until acknowledged
				tx_cur_q <= tx_nx_q;
				o_miso <= pick(tx_nx_q, 3'h0, i_lsb_first);
			end else begin
				o_miso <= pick(tx_cur_q, tx_cnt_q, i_lsb_first);
			end
		end
	end

	// Acknowledge toggle flips as each byte is taken
	always_ff @(posedge i_link_sclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tx_ack_q <= 1'b0;
		end else if (cs_act_raw && tx_cnt_q == 3'h0) begin
			tx_ack_q <= !tx_ack_q;
		end
	end

	// ****************************************************************
	// Toggle edge detection
	// ****************************************************************

	// Previous toggle levels, read only from the second stage
	always_ff @(posedge i_mclk) begin
		if (!rst_n_q) begin
			rx_tgl_d_q <= 1'b0;
			tx_ack_d_q <= 1'b0;
		end else begin
			rx_tgl_d_q <= sy_q[`BTHS_SY_RXTGL];
			tx_ack_d_q <= sy_q[`BTHS_SY_TXACK];
		end
	end

	// ****************************************************************
	// Receive buffer
	// ****************************************************************
	assign rx_full = (rx_wp_q - rx_rp_q) == (AW + 1)'(DEPTH);
	assign rx_empty = rx_wp_q == rx_rp_q;
	assign rx_push = rx_edge && spi_sel_q && !rx_full;
	assign rx_pop = !rx_empty && (!o_rx_valid || i_rx_ready);

	// Byte storage; stale contents are never read back
	always_ff @(posedge i_mclk) begin
		if (rx_push) begin
			rx_mem[rx_wp_q[AW-1:0]] <= rx_byte_q;
		end
	end

	// Pointers, output stage and overflow flag
	always_ff @(posedge i_mclk) begin
		if (!rst_n_q) begin
			rx_wp_q <= '0;
			rx_rp_q <= '0;
			o_rx_valid <= 1'b0;
			o_rx_data <= `BTHS_RST_BYTE;
			o_rx_overflow <= 1'b0;
		end else begin
			if (rx_push) begin
				rx_wp_q <= rx_wp_q + (AW + 1)'(1);
			end
			if (rx_pop) begin
				rx_rp_q <= rx_rp_q + (AW + 1)'(1);
				o_rx_data <= rx_mem[rx_rp_q[AW-1:0]];
				o_rx_valid <= 1'b1;
			end else if (i_rx_ready) begin
				o_rx_valid <= 1'b0;
			end
			// Raised when a byte arrives with all DEPTH entries unread
			if (rx_edge && spi_sel_q && rx_full) begin
				o_rx_overflow <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Transmit buffer
	// ****************************************************************
	assign tx_push = i_tx_valid && o_tx_ready;
	assign tx_load = spi_sel_q && !tx_nx_full_q && !ack_edge && (tx_wp_q != tx_rp_q);
	assign pend = tx_nx_full_q || (tx_wp_q != tx_rp_q);

	// Next pointer values feed the honest ready flag
	always_comb begin
		tx_wp_d = tx_wp_q;
		tx_rp_d = tx_rp_q;
		if (tx_push) begin
			tx_wp_d = tx_wp_q + (AW + 1)'(1);
		end
		if (tx_load) begin
			tx_rp_d = tx_rp_q + (AW + 1)'(1);
		end
	end

	// Byte storage for outgoing data
	always_ff @(posedge i_mclk) begin
		if (tx_push) begin
			tx_mem[tx_wp_q[AW-1:0]] <= i_tx_data;
		end
	end

	// Pointers and ready
	always_ff @(posedge i_mclk) begin
		if (!rst_n_q) begin
			tx_wp_q <= '0;
			tx_rp_q <= '0;
			o_tx_ready <= 1'b0;
		end else begin
			tx_wp_q <= tx_wp_d;
			tx_rp_q <= tx_rp_d;
			o_tx_ready <= (tx_wp_d - tx_rp_d) != (AW + 1)'(DEPTH);
		end
	end

	// Next-byte stage; changes only after the link has taken it
	always_ff @(posedge i_mclk) begin
		if (!rst_n_q) begin
			tx_nx_q <= `BTHS_RST_BYTE;
			tx_nx_full_q <= 1'b0;
		end else if (ack_edge) begin
			// Idle fill is zero when nothing is queued
			tx_nx_q <= `BTHS_RST_BYTE;
			tx_nx_full_q <= 1'b0;
		end else if (tx_load) begin
			tx_nx_q <= tx_mem[tx_rp_q[AW-1:0]];
			tx_nx_full_q <= 1'b1;
		end
	end

	// ****************************************************************
	// Transaction start negotiation
	// ****************************************************************

	// Next state of the interrupt handshake
	always_comb begin
		st_d = st_q;
		case (st_q)
			BTHS_ST_IDLE: begin
				if (cs_act_s) begin
					st_d = BTHS_ST_XFER;
				end else if (pend || i_xfer_ready) begin
					st_d = BTHS_ST_REQ;
				end
			end
			BTHS_ST_REQ: begin
				if (cs_act_s) begin
					st_d = BTHS_ST_XFER;
				end
			end
			BTHS_ST_XFER: begin
				if (!cs_act_s) begin
					st_d = BTHS_ST_IDLE;
				end
			end
			default: begin
				st_d = BTHS_ST_IDLE;
			end
		endcase
	end

	// State register; idle while another transport is chosen
	always_ff @(posedge i_mclk) begin
		if (!rst_n_q || !spi_sel_q) begin
			st_q <= BTHS_ST_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************************************
	// Pin drivers
	// ****************************************************************

	// Interrupt level in the chosen polarity
	always_ff @(posedge i_mclk) begin
		if (st_q == BTHS_ST_REQ) begin
			o_int <= i_int_active_high;
		end else begin
			o_int <= !i_int_active_high;
		end
	end

	// Enables: nothing driven in shutdown; data out only inside a frame
	always_ff @(posedge i_mclk) begin
		if (!rst_n_q) begin
			o_int_oe_n <= `BTHS_RST_OE_N;
			o_miso_oe_n <= `BTHS_RST_OE_N;
		end else begin
			o_int_oe_n <= !spi_sel_q;
			o_miso_oe_n <= !(spi_sel_q && cs_act_s);
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence s_start;
		(st_q == BTHS_ST_REQ) && cs_act_s;
	endsequence

	sequence s_pending;
		(st_q == BTHS_ST_IDLE) && pend && !cs_act_s && spi_sel_q;
	endsequence

	a_core_reset_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		!pwr_s |=> !o_core_reset_n)
		else $error("core reset released with power enable low");

	a_shutdown_quiet: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		!pwr_s |=> ##1 (o_miso_oe_n && o_int_oe_n))
		else $error("output driven during shutdown");

	a_power_clean: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		$rose(rst_n_q) |-> (rx_wp_q == rx_rp_q) && (st_q == BTHS_ST_IDLE) && !o_rx_valid)
		else $error("state survived power-up");

	a_strap_capture: assert property (@(posedge i_mclk) disable iff (!rst_n_q)
		!strap_done_q |=> (o_spi_selected == !$past(strap_s)))
		else $error("strap not captured");

	a_int_raise: assert property (@(posedge i_mclk) disable iff (!rst_n_q)
		s_pending |=> (st_q == BTHS_ST_REQ) ##1 (o_int == $past(i_int_active_high)))
		else $error("interrupt not raised for pending data");

	a_int_clear: assert property (@(posedge i_mclk) disable iff (!rst_n_q)
		s_start |=> (st_q == BTHS_ST_XFER) ##1 (o_int == !$past(i_int_active_high)))
		else $error("interrupt not cleared at transfer start");

	a_cs_undriven: assert property (@(posedge i_mclk) disable iff (!rst_n_q)
		!cs_act_s |=> o_miso_oe_n)
		else $error("data out driven without select");

	a_rx_stored: assert property (@(posedge i_mclk) disable iff (!rst_n_q)
		rx_edge && spi_sel_q && !rx_full |=> (rx_wp_q == $past(rx_wp_q) + 1'b1))
		else $error("received byte not stored");

	a_rx_overflow: assert property (@(posedge i_mclk) disable iff (!rst_n_q)
		rx_edge && spi_sel_q && rx_full |=> o_rx_overflow [*2])
		else $error("overflow not flagged");

	a_cs_polarity: assert property (@(posedge i_mclk) disable iff (!rst_n_q)
		spi_sel_q && (sy_q[`BTHS_SY_CS] == i_cs_active_high) |=> !o_miso_oe_n)
		else $error("select polarity ignored");
endmodule

`default_nettype wire

// [tb/bths_host_model.sv]
`default_nettype none

// ****************************************************************
// Serial master standing in for the host processor
// ****************************************************************
module bths_host_model (
	input wire logic i_miso,
	input wire logic i_cs_active_high,
	input wire logic i_lsb_first,
	output logic o_link_sclk,
	output logic o_slave_select,
	output logic o_mosi
);
	timeunit 1ns;
	timeprecision 1ns;

	localparam int HALF_NS = 80; // 6.25 MHz, well under the ceiling
	logic sel_q; // Frame open

	// Pin level follows the configured select polarity
	assign o_slave_select = sel_q ? i_cs_active_high : !i_cs_active_high;

	// Idle: clock low, select off
	initial begin
		sel_q = 1'b0;
		o_link_sclk = 1'b0;
		o_mosi = 1'b0;
	end

	// Open or close a frame, then settle over 5 core cycles
	task automatic set_sel(input logic on);
		#37;
		sel_q = on;
		o_mosi = ~o_mosi;
		#500;
	endtask

	// Shift n bits both ways; drive on rise, sample on fall
	task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
		int b;
		rx = 8'h00;
		for (int i = 0; i < n; i++) begin
			b = i_lsb_first ? i : 7 - i;
			o_link_sclk = 1'b1;
			o_mosi = tx[b];
			#HALF_NS;
			o_link_sclk = 1'b0;
			rx[b] = i_miso;
			#HALF_NS;
		end
		o_mosi = ~o_mosi;
	endtask

	// Clock edges with no frame open, which the device must ignore
	task automatic idle_edges(input int n);
		repeat (n) begin
			o_link_sclk = 1'b1;
			o_mosi = 1'b1;
			#HALF_NS;
			o_link_sclk = 1'b0;
			#HALF_NS;
		end
	endtask
endmodule

`default_nettype wire

// [tb/bths_spi_transport_tb_top.sv]
`default_nettype none
`define CHK(nm, e, g) check_val(nm, 32'(e), 32'(g))

// ****************************************************************
// Self-checking bench for the serial transport
// ****************************************************************
module bths_spi_transport_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int DEPTH = 16; // Small buffer keeps fills short
	localparam int LIMIT = 20000; // Cycle ceiling
	typedef struct {
		logic cs_hi;
		logic int_hi;
		logic lsb;
		logic xr;
		logic [7:0] tx;
		logic [7:0] mo;
	} bths_row_t;
	bths_row_t rows[4] = '{
		'{1'b0, 1'b0, 1'b0, 1'b0, 8'h3c, 8'ha1},
		'{1'b1, 1'b1, 1'b1, 1'b0, 8'hc5, 8'h17},
		'{1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 8'h82},
		'{1'b1, 1'b0, 1'b0, 1'b0, 8'h81, 8'h6e}};
	logic mclk, nrst, pwr_en, strap, cs_hi, int_hi, lsb, xfer_rdy, rx_rdy, tx_vld;
	logic [7:0] tx_dat, rx_dat, scratch;
	logic miso, miso_oe_n, int_o, int_oe_n, spi_sel, core_rst_n, rx_vld, tx_rdy, rx_ovf;
	wire logic sclk, sel, mosi, miso_w;
	int err_count = 0;
	int compares = 0;
	int cycles = 0;
	int n;

	// Released data line toggles so a stale bit cannot pass
	assign miso_w = miso_oe_n ? mclk : miso;

	bths_spi_transport #(.DEPTH(DEPTH)) dut (
		.i_mclk(mclk), .i_nrst(nrst), .i_link_sclk(sclk), .i_slave_select_in(sel),
		.i_mosi(mosi), .o_miso(miso), .o_miso_oe_n(miso_oe_n), .o_int(int_o),
		.o_int_oe_n(int_oe_n), .i_radio_core_power_enable(pwr_en),
		.i_host_wake_transport_strap(strap), .i_cs_active_high(cs_hi),
		.i_int_active_high(int_hi), .i_lsb_first(lsb), .i_xfer_ready(xfer_rdy),
		.o_spi_selected(spi_sel), .o_core_reset_n(core_rst_n), .o_rx_valid(rx_vld),
		.o_rx_data(rx_dat), .i_rx_ready(rx_rdy), .i_tx_valid(tx_vld), .i_tx_data(tx_dat),
		.o_tx_ready(tx_rdy), .o_rx_overflow(rx_ovf));

	bths_host_model m (
		.i_miso(miso_w), .i_cs_active_high(cs_hi), .i_lsb_first(lsb),
		.o_link_sclk(sclk), .o_slave_select(sel), .o_mosi(mosi));

	// Core clock, 100 ns period
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// Hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == LIMIT) begin
			err_count++;
			test_done();
		end
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Inputs move a fixed 10 ns after the edge
	task automatic step(input int c);
		repeat (c) @(posedge mclk);
		#10;
	endtask

	// Raise a pending cause, wait for the interrupt, then select
	task automatic open_frame(input logic xr);
		xfer_rdy = xr;
		for (int i = 0; i < 60 && int_o !== int_hi; i++) step(1);
		`CHK("int active", int_hi, int_o);
		m.set_sel(1'b1);
		step(1);
		`CHK("int idle", !int_hi, int_o);
		`CHK("miso enable", 1'b0, miso_oe_n);
		xfer_rdy = 1'b0;
	endtask

	task automatic close_frame();
		m.set_sel(1'b0);
		step(1);
		`CHK("miso released", 1'b1, miso_oe_n);
	endtask

	task automatic xfer(input logic [7:0] mo, input logic [7:0] exp);
		logic [7:0] r;
		m.shift(mo, 8, r);
		`CHK("miso byte", exp, r);
	endtask

	task automatic pop(input logic [7:0] exp);
		step(1);
		for (int i = 0; i < 30 && rx_vld !== 1'b1; i++) step(1);
		`CHK("rx byte", exp, rx_dat);
		rx_rdy = 1'b1;
		step(1);
		rx_rdy = 1'b0;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{nrst, pwr_en, strap, cs_hi, int_hi, lsb} = 6'h10;
		{xfer_rdy, rx_rdy, tx_vld, tx_dat} = 11'h000;
		step(12);
		`CHK("reset miso oe", 1'b1, miso_oe_n);
		`CHK("reset core", 1'b0, core_rst_n);
		`CHK("reset tx ready", 1'b0, tx_rdy);
		nrst = 1'b1;
		step(8);
		`CHK("core out of reset", 1'b1, core_rst_n);
		`CHK("strap low", 1'b1, spi_sel);
		`CHK("int driven", 1'b0, int_oe_n);
		`CHK("int idle", 1'b1, int_o);
		`CHK("rx empty", 1'b0, rx_vld);
		$display("reset test done");

		// Polarity and bit order rows
		foreach (rows[k]) begin
			{cs_hi, int_hi, lsb} = {rows[k].cs_hi, rows[k].int_hi, rows[k].lsb};
			step(2);
			if (!rows[k].xr) begin
				tx_vld = 1'b1;
				tx_dat = rows[k].tx;
				step(1);
				tx_vld = 1'b0;
			end
			open_frame(rows[k].xr);
			xfer(rows[k].mo, rows[k].tx);
			close_frame();
			pop(rows[k].mo);
			$display("row %0d done", k);
		end

		// Three bytes in one frame with no stall
		tx_vld = 1'b1;
		for (int i = 0; i < 3; i++) begin
			tx_dat = 8'h10 + 8'(i);
			step(1);
		end
		tx_vld = 1'b0;
		open_frame(1'b0);
		for (int i = 0; i < 3; i++) xfer(8'h20 + 8'(i), 8'h10 + 8'(i));
		close_frame();
		for (int i = 0; i < 3; i++) pop(8'h20 + 8'(i));
		$display("burst test done");

		// Edges while deselected and a cut byte are both dropped
		m.idle_edges(12);
		open_frame(1'b1);
		m.shift(8'hff, 3, scratch);
		close_frame();
		step(3);
		`CHK("no rx after cut", 1'b0, rx_vld);
		open_frame(1'b1);
		xfer(8'h5a, 8'h00);
		close_frame();
		pop(8'h5a);
		$display("realign test done");

		// Fill the send buffer, then one long frame with the consumer stalled
		n = 0;
		tx_vld = 1'b1;
		for (int i = 0; i < 40 && tx_rdy === 1'b1; i++) begin
			tx_dat = 8'(i);
			step(1);
			n++;
		end
		tx_vld = 1'b0;
		`CHK("tx full", 1'b0, tx_rdy);
		`CHK("whole packet held", 1'b1, n >= DEPTH);
		open_frame(1'b0);
		for (int i = 0; i < DEPTH + 2; i++) begin
			m.shift(8'h40 + 8'(i), 8, scratch);
			if (i < DEPTH) `CHK("drain order", 8'(i), scratch);
		end
		close_frame();
		step(6);
		`CHK("tx ready again", 1'b1, tx_rdy);
		`CHK("rx overflow", 1'b1, rx_ovf);
		pop(8'h40);
		$display("fill test done");

		// Shutdown, power-up with strap high, then with strap low
		tx_vld = 1'b1;
		tx_dat = 8'h99;
		step(1);
		tx_vld = 1'b0;
		step(6);
		pwr_en = 1'b0;
		step(4);
		`CHK("off core", 1'b0, core_rst_n);
		`CHK("off miso oe", 1'b1, miso_oe_n);
		`CHK("off int oe", 1'b1, int_oe_n);
		`CHK("off rx", 1'b0, rx_vld);
		strap = 1'b1;
		pwr_en = 1'b1;
		step(8);
		`CHK("on core", 1'b1, core_rst_n);
		`CHK("strap high", 1'b0, spi_sel);
		pwr_en = 1'b0;
		step(4);
		strap = 1'b0;
		pwr_en = 1'b1;
		step(8);
		`CHK("strap low again", 1'b1, spi_sel);
		`CHK("overflow lost", 1'b0, rx_ovf);
		`CHK("pending lost", !int_hi, int_o);
		`CHK("int driven", 1'b0, int_oe_n);
		$display("shutdown test done");
		test_done();
	end
endmodule

`default_nettype wire
